/* File: logic/pld_pkg.sv */
/*
 * constants and types of the macrocell logic array
 * assumes one 100 MHz system clock and a plain register port
 */
package pld_pkg;
    localparam int MC_N = 32;
    localparam int IN_N = 4;
    localparam int PIN_N = 36;
    localparam int GSIG_N = 34;
    localparam int GBUS_W = 68;
    localparam int REGION_N = 16;
    localparam int PT_N = 5;
    localparam int ARR_W = 84;
    localparam int CHAIN_LEN = 8;
    localparam int WORDS_PER_PT = 3;
    localparam int PT_WORDS = 480;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] PT_END = 10'h1E0;
    localparam logic [ADDR_W-1:0] CTRL_BASE = 10'h200;
    localparam logic [ADDR_W-1:0] CTRL_END = 10'h220;
    localparam logic [ADDR_W-1:0] GLOBAL_ADDR = 10'h220;
    localparam logic [ADDR_W-1:0] PINS_ADDR = 10'h221;
    localparam logic [ADDR_W-1:0] QREG_ADDR = 10'h222;
    localparam logic [ADDR_W-1:0] STAT_ADDR = 10'h223;

    // dedicated input pins, then the sleep request i/o pin and its synchroniser bit
    localparam int CLK_PIN = 0;
    localparam int CLR_PIN = 1;
    localparam int OE1_PIN = 2;
    localparam int OE2_PIN = 3;
    localparam int SLEEP_IO = 31;
    localparam int SLEEP_BIT = 35;

    // macrocell control word
    localparam int F_OR = 0;
    localparam int F_XOR = 5;
    localparam int F_CAS = 7;
    localparam int F_REGOUT = 8;
    localparam int F_CLKPT = 9;
    localparam int F_CLR = 10;
    localparam int F_OE = 12;
    localparam int F_FAST = 14;
    localparam int F_FOLD = 15;

    localparam logic [1:0] XOR_LOW = 2'h0;
    localparam logic [1:0] XOR_HIGH = 2'h1;
    localparam logic [1:0] XOR_PT = 2'h2;
    localparam logic [1:0] XOR_FB = 2'h3;
    localparam logic [1:0] OE_OFF = 2'h0;
    localparam logic [1:0] OE_ON = 2'h1;
    localparam logic [1:0] OE_ONE = 2'h2;
    localparam logic [1:0] OE_TWO = 2'h3;

    // product terms with a fixed second role
    localparam int PT_CLK = 2;
    localparam int PT_CLR = 3;
    localparam int PT_XOR = 4;

    localparam int G_RUN = 0;
    localparam int G_KEEP = 1;
    localparam int G_PD = 2;
    localparam logic [DATA_W-1:0] GLOBAL_RST = 32'h00000002;

    typedef enum logic [2:0] {
        ST_CFG = 3'b001,
        ST_RUN = 3'b010,
        ST_SLEEP = 3'b100
    } mode_e;
endpackage

/* File: logic/pld_logic_array.sv */
/*
 * logic fabric of a 32-macrocell programmable logic device:
 * global and regional busses, product terms, term allocation,
 * or/xor/chain sum, macrocell register, pin keepers, standby and sleep.
 * assumes the board tells which pins it leaves floating, and that
 * configuration is written while the array is stopped.
 */
// Notes on behaviour
// - every macrocell not OE_OFF feeds back to the global bus, seen by all; an OE_OFF one puts its pin there, except the sleep pin with sleep option set
// - dedicated inputs serve as clock, clear or enable, chosen per macrocell
// - each macrocell drives one foldback onto its 16-macrocell region
// - four chains of eight macrocells sum up to forty product terms
// - with keeper on, a released pin keeps its last driven level
// - keeper can be switched off; then floating pins are not held
// - standby flags itself when nothing toggles, without losing function
// - with sleep option set, a high sleep request pin powers down
// - power-down freezes internal signals and enabled outputs
// - pin changes are ignored in power-down until sleep pin falls
// - sleep pin is no logic input or output; its macrocell stays buried
// - outputs switch slowly unless configured fast per output
// - five product terms each see global and regional bus
// - term allocation mux routes terms to gates or control roles
// - five terms may form one sum, extended by the chain input
// - xor second input is a term, register feedback, constant high or constant low
// - the constant picks true or inverted combinational output
// - xor with register feedback emulates a toggle register
// - global register clear is active low, per selecting macrocell
// - both output enable pins active low, drive only while low
// - terms see true and complement of the global bus, 68 wide
// - foldback is the inverse of one selected product term
`timescale 1ns/1ps
module pld_logic_array
    import pld_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [pld_pkg::ADDR_W-1:0] addr_i,
    input wire logic [pld_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [pld_pkg::DATA_W-1:0] rdata_o,
    input wire logic [pld_pkg::IN_N-1:0] in_pin_i,
    input wire logic [pld_pkg::IN_N-1:0] in_undriven_i,
    input wire logic [pld_pkg::MC_N-1:0] io_in_i,
    input wire logic [pld_pkg::MC_N-1:0] io_undriven_i,
    output logic [pld_pkg::MC_N-1:0] io_out_o,
    output logic [pld_pkg::MC_N-1:0] io_oe_n_o,
    output logic [pld_pkg::MC_N-1:0] io_fast_o,
    output logic standby_o,
    output logic sleep_o
);
    import pld_pkg::*;

    typedef struct packed {
        mode_e mode;
        logic [PT_WORDS-1:0][DATA_W-1:0] pt_mem;
        logic [MC_N-1:0][DATA_W-1:0] ctrl;
        logic [DATA_W-1:0] glob;
        logic [2*PIN_N-1:0] sy1;
        logic [2*PIN_N-1:0] sy2;
        logic [2*PIN_N-1:0] sy3;
        logic [2*PIN_N-1:0] stab;
        logic [PIN_N-1:0] held;
        logic [MC_N-1:0] q;
        logic [MC_N-1:0] comb;
        logic [MC_N-1:0] fold;
        logic [MC_N-1:0] pt2_prev;
        logic [MC_N-1:0] io_out;
        logic [MC_N-1:0] oe;
        logic clk_prev;
        logic stby;
        logic [DATA_W-1:0] rdata;
    } state_s;

    state_s r_reg;
    state_s r_next;

    // and-plane: an empty mask means an unused term, which stays low
    function automatic logic pt_eval(input logic [ARR_W-1:0] mask, input logic [ARR_W-1:0] arr);
        pt_eval = (mask != '0) && (&(arr | ~mask));
    endfunction

    function automatic logic [PIN_N-1:0] pin_level(input state_s s);
        logic [PIN_N-1:0] lvl;
        lvl = '0;
        for (int k = 0; k < PIN_N; k++)
        begin
            if (s.stab[PIN_N+k] && s.glob[G_KEEP])
            begin
                lvl[k] = s.held[k];
            end
            else
            begin
                lvl[k] = s.stab[k];
            end
        end
        pin_level = lvl;
    endfunction

    always_comb
    begin
        logic [PIN_N-1:0] lvl;
        logic [MC_N-1:0] fb;
        logic [GSIG_N-1:0] gsig;
        logic [GBUS_W-1:0] gbus;
        logic [REGION_N-1:0] regv;
        logic [ARR_W-1:0] arr;
        logic [ARR_W-1:0] mask;
        logic [PT_N-1:0] pt;
        logic [MC_N-1:0] sum_v;
        logic [DATA_W-1:0] c;
        logic xor2;
        logic d;
        logic clk_ev;
        logic clr;
        logic gclk_edge;
        logic pd_opt;
        logic sleep_hi;
        logic sleep_lo;
        logic running;
        int b;
        int fs;
        lvl = '0;
        fb = '0;
        gsig = '0;
        gbus = '0;
        regv = '0;
        arr = '0;
        mask = '0;
        pt = '0;
        sum_v = '0;
        c = '0;
        xor2 = 1'b0;
        d = 1'b0;
        clk_ev = 1'b0;
        clr = 1'b0;
        b = 0;
        fs = 0;
        gclk_edge = 1'b0;
        pd_opt = 1'b0;
        sleep_hi = 1'b0;
        sleep_lo = 1'b0;
        running = 1'b0;
        r_next = r_reg;

        // three-stage synchroniser; a bit settles once stages two and three agree
        r_next.sy1 = {io_undriven_i, in_undriven_i, io_in_i, in_pin_i};
        r_next.sy2 = r_reg.sy1;
        r_next.sy3 = r_reg.sy2;
        pd_opt = r_reg.glob[G_PD];
        sleep_hi = r_reg.sy2[SLEEP_BIT] && r_reg.sy3[SLEEP_BIT];
        sleep_lo = !r_reg.sy2[SLEEP_BIT] && !r_reg.sy3[SLEEP_BIT];
        running = (r_reg.mode == ST_RUN);

        if (running)
        begin
            for (int k = 0; k < 2*PIN_N; k++)
            begin
                if (r_reg.sy2[k] == r_reg.sy3[k])
                begin
                    r_next.stab[k] = r_reg.sy2[k];
                end
            end
            for (int k = 0; k < PIN_N; k++)
            begin
                if (!r_reg.stab[PIN_N+k])
                begin
                    r_next.held[k] = r_reg.stab[k];
                end
            end
        end

        lvl = pin_level(r_reg);
        gclk_edge = lvl[CLK_PIN] && !r_reg.clk_prev;

        // feedback is registered so the array has no combinational loop
        for (int i = 0; i < MC_N; i++)
        begin
            c = r_reg.ctrl[i];
            fb[i] = c[F_REGOUT] ? r_reg.q[i] : r_reg.comb[i];
            if (c[F_OE +: 2] == OE_OFF || (pd_opt && i == SLEEP_IO))
            begin
                gsig[i] = fb[i];
            end
            else
            begin
                gsig[i] = fb[i];
            end
            if (c[F_OE +: 2] == OE_OFF && !(pd_opt && i == SLEEP_IO))
            begin
                gsig[i] = lvl[IN_N+i];
            end
        end
        gsig[MC_N] = lvl[OE1_PIN];
        gsig[MC_N+1] = lvl[OE2_PIN];
        gbus = {~gsig, gsig};

        for (int i = 0; i < MC_N; i++)
        begin
            c = r_reg.ctrl[i];
            regv = r_reg.fold[(i/REGION_N)*REGION_N +: REGION_N];
            arr = {regv, gbus};
            for (int j = 0; j < PT_N; j++)
            begin
                b = (i*PT_N + j)*WORDS_PER_PT;
                mask = ARR_W'({r_reg.pt_mem[b+2], r_reg.pt_mem[b+1], r_reg.pt_mem[b]});
                pt[j] = pt_eval(mask, arr);
            end

            // term allocation mux: or-plane enables plus fixed control roles
            sum_v[i] = |(pt & c[F_OR +: PT_N]);
            if (c[F_CAS] && (i % CHAIN_LEN) != 0)
            begin
                sum_v[i] = sum_v[i] | sum_v[i-1];
            end

            unique case (c[F_XOR +: 2])
                XOR_LOW: xor2 = 1'b0;
                XOR_HIGH: xor2 = 1'b1;
                XOR_PT: xor2 = pt[PT_XOR];
                XOR_FB: xor2 = r_reg.q[i];
            endcase
            d = sum_v[i] ^ xor2;

            fs = int'(c[F_FOLD +: 3]);
            if (fs >= PT_N)
            begin
                fs = 0;
            end

            clk_ev = c[F_CLKPT] ? (pt[PT_CLK] && !r_reg.pt2_prev[i]) : gclk_edge;
            clr = (c[F_CLR] && !lvl[CLR_PIN]) || (c[F_CLR+1] && pt[PT_CLR]);

            if (running)
            begin
                r_next.comb[i] = d;
                r_next.fold[i] = ~pt[fs];
                r_next.pt2_prev[i] = pt[PT_CLK];
                if (clr)
                begin
                    r_next.q[i] = 1'b0;
                end
                else if (clk_ev)
                begin
                    r_next.q[i] = d;
                end
                r_next.io_out[i] = c[F_REGOUT] ? r_next.q[i] : d;
                unique case (c[F_OE +: 2])
                    OE_OFF: r_next.oe[i] = 1'b0;
                    OE_ON: r_next.oe[i] = 1'b1;
                    OE_ONE: r_next.oe[i] = !lvl[OE1_PIN];
                    OE_TWO: r_next.oe[i] = !lvl[OE2_PIN];
                endcase
                if (pd_opt && i == SLEEP_IO)
                begin
                    r_next.oe[i] = 1'b0;
                end
            end
            else if (r_reg.mode == ST_CFG)
            begin
                r_next.oe[i] = 1'b0;
            end
        end

        if (running)
        begin
            r_next.clk_prev = lvl[CLK_PIN];
        end


        unique case (r_reg.mode)
            ST_CFG:
            begin
                if (r_reg.glob[G_RUN])
                begin
                    r_next.mode = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (!r_reg.glob[G_RUN])
                begin
                    r_next.mode = ST_CFG;
                end
                else if (pd_opt && sleep_hi)
                begin
                    r_next.mode = ST_SLEEP;
                end
            end
            ST_SLEEP:
            begin
                if (!r_reg.glob[G_RUN])
                begin
                    r_next.mode = ST_CFG;
                end
                else if (sleep_lo || !pd_opt)
                begin
                    r_next.mode = ST_RUN;
                end
            end
            default:
            begin
                r_next.mode = ST_CFG;
            end
        endcase

        // standby only if nothing changed and the array stays running, so it never overlaps sleep
        r_next.stby = running && (r_next.mode == ST_RUN) && (r_next.stab == r_reg.stab)
            && (r_next.q == r_reg.q) && (r_next.comb == r_reg.comb)
            && (r_next.fold == r_reg.fold);

        // register port; array configuration is locked while running
        if (wr_i)
        begin
            if (addr_i < PT_END && !r_reg.glob[G_RUN])
            begin
                r_next.pt_mem[addr_i] = wdata_i;
            end
            else if (addr_i >= CTRL_BASE && addr_i < CTRL_END && !r_reg.glob[G_RUN])
            begin
                r_next.ctrl[addr_i - CTRL_BASE] = wdata_i;
            end
            else if (addr_i == GLOBAL_ADDR)
            begin
                r_next.glob = wdata_i;
            end
        end

        r_next.rdata = '0;
        if (rd_i)
        begin
            if (addr_i < PT_END)
            begin
                r_next.rdata = r_reg.pt_mem[addr_i];
            end
            else if (addr_i >= CTRL_BASE && addr_i < CTRL_END)
            begin
                r_next.rdata = r_reg.ctrl[addr_i - CTRL_BASE];
            end
            else if (addr_i == GLOBAL_ADDR)
            begin
                r_next.rdata = r_reg.glob;
            end
            else if (addr_i == PINS_ADDR)
            begin
                r_next.rdata = lvl[IN_N +: MC_N];
            end
            else if (addr_i == QREG_ADDR)
            begin
                r_next.rdata = r_reg.q;
            end
            else if (addr_i == STAT_ADDR)
            begin
                r_next.rdata = {lvl[IN_N-1:0], 23'h000000, r_reg.mode, r_reg.stby, (r_reg.mode == ST_SLEEP)};
            end
        end

        if (sys_rst_i)
        begin
            r_next = '0;
            r_next.mode = ST_CFG;
            r_next.glob = GLOBAL_RST;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        r_reg <= r_next;
    end

    always_comb
    begin
        rdata_o = r_reg.rdata;
        io_out_o = r_reg.io_out;
        io_oe_n_o = ~r_reg.oe;
        standby_o = r_reg.stby;
        sleep_o = (r_reg.mode == ST_SLEEP);
        for (int i = 0; i < MC_N; i++)
        begin
            io_fast_o[i] = r_reg.ctrl[i][F_FAST];
        end
    end
endmodule

/* File: bench/pld_logic_array_checker.sv */
/* port assertions of the macrocell logic array
   bound to the design top, sees only its ports */
`timescale 1ns/1ps
module pld_logic_array_checker
    import pld_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [9:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [31:0] io_in_i,
    input wire logic [31:0] io_out_o,
    input wire logic [31:0] io_oe_n_o,
    input wire logic [31:0] io_fast_o,
    input wire logic standby_o,
    input wire logic sleep_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // bench writes leave one idle cycle before the next read
    sequence glob_wr_rd;
        wr_i && addr_i == GLOBAL_ADDR ##2 rd_i && addr_i == GLOBAL_ADDR;
    endsequence
    a_read_idle_zero: assert property (!rd_i |=> rdata_o == '0)
        else $error("read data not idle");
    a_glob_read_back: assert property (glob_wr_rd |=> rdata_o[2:0] == $past(wdata_i[2:0], 3))
        else $error("global word lost");
    a_unmapped_read_zero: assert property (rd_i && addr_i > STAT_ADDR |=> rdata_o == '0)
        else $error("unmapped read not zero");
    a_mode_one_hot: assert property (rd_i && addr_i == STAT_ADDR |=> $onehot(rdata_o[4:2]))
        else $error("mode field not one-hot");
    a_sleep_entry_pin: assert property ($rose(sleep_o) |-> $past(io_in_i[SLEEP_IO]))
        else $error("sleep without request pin");
    a_sleep_freeze_out: assert property (sleep_o && $past(sleep_o) && $past(sleep_o, 2) |->
        $stable(io_out_o) && $stable(io_oe_n_o))
        else $error("outputs moved in sleep");
    a_sleep_exit_pin: assert property ($fell(sleep_o) |-> !$past(io_in_i[SLEEP_IO]))
        else $error("sleep left with pin high");
    a_sleep_pin_quiet: assert property (sleep_o |-> io_oe_n_o[SLEEP_IO])
        else $error("sleep pin driven");
    a_standby_not_sleep: assert property (standby_o |-> !sleep_o)
        else $error("standby during sleep");
    a_fast_after_write: assert property (!$stable(io_fast_o) |-> $past(wr_i) || $past(wr_i, 2))
        else $error("slew changed without write");
endmodule
bind pld_logic_array pld_logic_array_checker pld_logic_array_checker_i (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .io_in_i(io_in_i), .io_out_o(io_out_o), .io_oe_n_o(io_oe_n_o),
    .io_fast_o(io_fast_o), .standby_o(standby_o), .sleep_o(sleep_o));

/* File: bench/pld_board_model.sv */
/* board side of the i/o pins: resolves each wire
   assumes the bench never drives a pin the device drives */
`timescale 1ns/1ps
module pld_board_model
    import pld_pkg::*;
(
    input wire logic clk_i,
    input wire logic [pld_pkg::MC_N-1:0] drv_en_i,
    input wire logic [pld_pkg::MC_N-1:0] drv_val_i,
    input wire logic [pld_pkg::MC_N-1:0] dev_out_i,
    input wire logic [pld_pkg::MC_N-1:0] dev_oe_n_i,
    output logic [pld_pkg::MC_N-1:0] level_o,
    output logic [pld_pkg::MC_N-1:0] undriven_o
);
    logic [MC_N-1:0] last_reg = '0;
    // a floating wire shows the inverse of its last level, so a missing keeper shows up
    always_comb
    begin
        for (int k = 0; k < MC_N; k++)
        begin
            undriven_o[k] = dev_oe_n_i[k] && !drv_en_i[k];
            if (!dev_oe_n_i[k])
                level_o[k] = dev_out_i[k];
            else if (drv_en_i[k])
                level_o[k] = drv_val_i[k];
            else
                level_o[k] = ~last_reg[k];
        end
    end
    always_ff @(posedge clk_i)
        last_reg <= (level_o & ~undriven_o) | (last_reg & undriven_o);
endmodule

/* File: bench/tb.sv */
/* self-checking bench of the macrocell logic array
   assumes the board model resolves the i/o pins */
`timescale 1ns/1ps
module tb;
    import pld_pkg::*;
    logic sys_clk_i = 0;
    logic sys_rst_i = 1;
    logic wr_i = 0;
    logic rd_i = 0;
    logic standby_o, sleep_o;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic [DATA_W-1:0] rdata_o, got;
    logic [IN_N-1:0] in_pin_i = 4'hA;
    // sleep pin held low by the board; a floating pin would read high and force sleep
    logic [MC_N-1:0] drv_en = 32'hFFFFFFFE;
    logic [MC_N-1:0] drv_val = 32'h00000004;
    logic [MC_N-1:0] io_in_i, io_undriven_i, io_out_o, io_oe_n_o, io_fast_o;
    int err_count = 0;
    int cmp_count = 0;
    initial
        forever #5 sys_clk_i = ~sys_clk_i;
    pld_logic_array pld_logic_array_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .in_pin_i(in_pin_i),
        .in_undriven_i(4'h0), .io_in_i(io_in_i), .io_undriven_i(io_undriven_i), .io_out_o(io_out_o),
        .io_oe_n_o(io_oe_n_o), .io_fast_o(io_fast_o), .standby_o(standby_o), .sleep_o(sleep_o));
    pld_board_model pld_board_model_i (.clk_i(sys_clk_i), .drv_en_i(drv_en), .drv_val_i(drv_val),
        .dev_out_i(io_out_o), .dev_oe_n_i(io_oe_n_o), .level_o(io_in_i), .undriven_o(io_undriven_i));
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 got = rdata_o;
    endtask
    function automatic logic pick(input int sel);
        return sel == 0 ? io_out_o[0] : sel == 1 ? io_oe_n_o[0] : sleep_o;
    endfunction
    task automatic wait_bit(input int sel, input logic v);
        int n;
        n = 0;
        #1;
        while (pick(sel) !== v && n < 40)
        begin
            @(posedge sys_clk_i);
            #1 n++;
        end
        if (pick(sel) !== v)
        begin
            err_count++;
            $display("unexpected at %0t: wait ran out", $time);
            report_and_stop();
        end
        check({31'h0, pick(sel)}, {31'h0, v});
    endtask
    // pins need three synchroniser edges plus array cycles, twelve is ample
    task automatic held(input int sel, input logic v);
        repeat (12) @(posedge sys_clk_i);
        #1 check({31'h0, pick(sel)}, {31'h0, v});
    endtask
    // one clock pin pulse, each level long enough to pass the synchroniser
    task automatic clk_pulse();
        @(posedge sys_clk_i);
        in_pin_i[CLK_PIN] <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        in_pin_i[CLK_PIN] <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
    endtask
    task automatic pin(input int k, input logic en, input logic v);
        @(posedge sys_clk_i);
        drv_en[k] <= en;
        drv_val[k] <= v;
    endtask
    task automatic term(input int t, input logic [ARR_W-1:0] m);
        logic [ADDR_W-1:0] b;
        b = ADDR_W'(t * WORDS_PER_PT);
        wr(b, m[31:0]);
        wr(b + 10'h1, m[63:32]);
        wr(b + 10'h2, {12'h000, m[83:64]});
    endtask
    // configuration is locked while running, so stop first
    task automatic setup(input logic [DATA_W-1:0] ctrl, input logic [2:0] glob);
        wr(GLOBAL_ADDR, 32'h2);
        wr(CTRL_BASE, ctrl);
        wr(GLOBAL_ADDR, {29'h0, glob});
        rd(GLOBAL_ADDR);
        check(got, {29'h0, glob});
    endtask
    initial
    begin
        repeat (8) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rd(GLOBAL_ADDR);
        check(got, GLOBAL_RST);
        rd(10'h3FF);
        check(got, 32'h0);
        rd(STAT_ADDR);
        check(got & 32'h1C, 32'h4);
        check(io_fast_o, 32'h0);
        $display("test reset done");
        term(0, 84'h2);
        term(1, 84'h1 << 36);
        term(2, 84'h1 << 68);
        wr(CTRL_BASE + 10'h1, 32'h180);
        setup(32'h5003, 3'b011);
        wr(CTRL_BASE, 32'h0);
        rd(CTRL_BASE);
        check(got, 32'h5003);
        check(io_fast_o, 32'h1);
        wait_bit(1, 1'b0);
        wait_bit(0, 1'b0);
        pin(2, 1'b1, 1'b0);
        wait_bit(0, 1'b1);
        pin(2, 1'b1, 1'b1);
        wait_bit(0, 1'b0);
        pin(1, 1'b1, 1'b1);
        wait_bit(0, 1'b1);
        $display("test sum done");
        pin(1, 1'b0, 1'b0);
        held(0, 1'b1);
        check({31'h0, standby_o}, 32'h1);
        setup(32'h5003, 3'b001);
        wait_bit(0, 1'b0);
        pin(1, 1'b1, 1'b1);
        $display("test keeper done");
        setup(32'h5023, 3'b011);
        wait_bit(0, 1'b0);
        $display("test polarity done");
        setup(32'h2003, 3'b011);
        wait_bit(0, 1'b1);
        check(io_fast_o, 32'h0);
        wait_bit(1, 1'b0);
        @(posedge sys_clk_i);
        in_pin_i[OE1_PIN] <= 1'b1;
        wait_bit(1, 1'b1);
        @(posedge sys_clk_i);
        in_pin_i[OE1_PIN] <= 1'b0;
        wait_bit(1, 1'b0);
        $display("test enable done");
        setup(32'h2003, 3'b111);
        pin(SLEEP_IO, 1'b1, 1'b1);
        wait_bit(2, 1'b1);
        pin(1, 1'b1, 1'b0);
        held(0, 1'b1);
        check({31'h0, io_oe_n_o[SLEEP_IO]}, 32'h1);
        pin(SLEEP_IO, 1'b1, 1'b0);
        wait_bit(2, 1'b0);
        wait_bit(0, 1'b0);
        $display("test sleep done");
        pin(1, 1'b1, 1'b1);
        setup(32'h1561, 3'b011);
        clk_pulse();
        rd(QREG_ADDR);
        check(got, 32'h3);
        clk_pulse();
        rd(QREG_ADDR);
        check(got, 32'h2);
        clk_pulse();
        @(posedge sys_clk_i);
        in_pin_i[CLR_PIN] <= 1'b0;
        wait_bit(0, 1'b0);
        rd(QREG_ADDR);
        check(got, 32'h2);
        $display("test register done");
        setup(32'h9004, 3'b011);
        wait_bit(0, 1'b1);
        pin(2, 1'b1, 1'b0);
        wait_bit(0, 1'b0);
        $display("test foldback done");
        report_and_stop();
    end
endmodule
